// ### hdl/uart_irq_top.sv
// channel interrupt sources, priority status and fifo control registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.svh"

module uart_irq_top
  import uart_irq_pkg::*;
(
  // clock and reset
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  // axi4-lite write address and data
  input  wire logic [7:0]             S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]                  S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]             S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  // channel status and strobes
  input  wire uart_irq_pkg::uart_evt_s EVENTS,
  input  wire logic [7:0]             PROG_RX_TRIGGER,
  input  wire logic [7:0]             PROG_TX_TRIGGER,
  // flow control pins, asynchronous
  input  wire logic                   CTS_N_PIN,
  input  wire logic                   DSR_N_PIN,
  // controls to the channel
  output logic                        FIFO_ENABLE,
  output logic                        AUTO_RS485,
  output logic                        RX_FIFO_RESET,
  output logic                        TX_FIFO_RESET,
  output logic [7:0]                  RX_TRIGGER,
  output logic [7:0]                  TX_TRIGGER,
  // interrupt requests
  output logic                        CHANNEL_IRQ,
  output logic                        WAKE_IRQ
);

  import uart_irq_pkg::*;

  //--------------------------------------------------------------------
  // reset release
  //--------------------------------------------------------------------
  logic [1:0] rst_pipe_r;
  logic       rst_n;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_r[1];

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  state_s     s_r;
  state_s     s_nxt;
  logic [7:0] rx_level;
  logic [7:0] tx_level;
  logic [5:0] code;

  trigger_table u_trigger_table (
    .TABLE_SEL (s_r.feature_control[`FT_TABLE]),
    .RX_SEL    (s_r.rx_trg_sel),
    .TX_SEL    (s_r.tx_trg_sel),
    .PROG_RX   (PROG_RX_TRIGGER),
    .PROG_TX   (PROG_TX_TRIGGER),
    .RX_LEVEL  (rx_level),
    .TX_LEVEL  (tx_level)
  );

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == `ADDR_INT_ENABLE)  ||
                  (addr == `ADDR_INT_STATUS)  ||
                  (addr == `ADDR_FIFO_CTRL)   ||
                  (addr == `ADDR_FEATURE)     ||
                  (addr == `ADDR_ENH_FEATURE) ||
                  (addr == `ADDR_MODEM_CTRL);
  endfunction

  //--------------------------------------------------------------------
  // source levels and priority
  //--------------------------------------------------------------------
  logic rx_data_act;
  logic rx_nonempty;

  assign rx_nonempty = (EVENTS.rx_count != 9'h000);

  // level source: it drops by itself once reads take the count down
  assign rx_data_act = s_r.interrupt_enable[`IEN_RX_DATA] &
    (s_r.fifo_en ? (EVENTS.rx_count >= {1'b0, rx_level})
                 : rx_nonempty);

  // only the top source is shown; lower ones wait in their flags
  always_comb begin
    if (s_r.line_pend) begin
      code = `CODE_LINE;
    end else if (rx_data_act) begin
      code = `CODE_RX_DATA;
    end else if (s_r.timeout_pend) begin
      code = `CODE_TIMEOUT;
    end else if (s_r.tx_pend) begin
      code = `CODE_TX_READY;
    end else if (s_r.modem_pend) begin
      code = `CODE_MODEM;
    end else if (s_r.flow_char_pend) begin
      code = `CODE_FLOW_CHAR;
    end else if (s_r.flow_pin_pend) begin
      code = `CODE_FLOW_PIN;
    end else begin
      code = `CODE_NONE;
    end
  end

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  always_comb begin
    logic       aw_ok;
    logic       w_ok;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic       wlane;
    logic       do_wr;
    logic       isr_rd;
    logic       tx_below;
    logic       tx_empty;
    logic       tx_set;
    logic       flow_in;
    logic       flow_out;
    logic [6:0] to_limit;
    logic       to_fire;
    aw_ok    = 1'b0;
    w_ok     = 1'b0;
    waddr    = 8'h00;
    wdata    = 8'h00;
    wlane    = 1'b0;
    do_wr    = 1'b0;
    isr_rd   = 1'b0;
    tx_below = 1'b0;
    tx_empty = 1'b0;
    tx_set   = 1'b0;
    flow_in  = 1'b0;
    flow_out = 1'b0;
    to_limit = 7'h00;
    to_fire  = 1'b0;
    s_nxt    = s_r;

    s_nxt.rx_fifo_rst = 1'b0;
    s_nxt.tx_fifo_rst = 1'b0;

    // write: address and data are taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_data  = S_AXI_WDATA[7:0];
      s_nxt.w_lane0 = S_AXI_WSTRB[0];
    end
    aw_ok = s_r.aw_held | (S_AXI_AWVALID & S_AXI_AWREADY);
    w_ok  = s_r.w_held | (S_AXI_WVALID & S_AXI_WREADY);
    waddr = s_r.aw_held ? s_r.aw_addr : S_AXI_AWADDR;
    wdata = s_r.w_held ? s_r.w_data : S_AXI_WDATA[7:0];
    wlane = s_r.w_held ? s_r.w_lane0 : S_AXI_WSTRB[0];
    if (aw_ok && w_ok && !s_r.bvalid) begin
      do_wr         = wlane;
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = addr_mapped(waddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    if (do_wr) begin
      unique case (waddr)
        `ADDR_INT_ENABLE:  s_nxt.interrupt_enable  = wdata;
        `ADDR_FEATURE:     s_nxt.feature_control = wdata;
        `ADDR_ENH_FEATURE: s_nxt.enhanced_feature  = wdata;
        `ADDR_MODEM_CTRL:  s_nxt.modem_control  = wdata;
        `ADDR_FIFO_CTRL: begin
          s_nxt.fifo_en = wdata[`FC_ENABLE];
          if (wdata[`FC_ENABLE]) begin
            s_nxt.rx_trg_sel  = wdata[`FC_RX_TRG];
            s_nxt.rx_fifo_rst = wdata[`FC_RX_RST];
            s_nxt.tx_fifo_rst = wdata[`FC_TX_RST];
            if (s_r.enhanced_feature[`EF_ENHANCED]) begin
              s_nxt.tx_trg_sel = wdata[`FC_TX_TRG];
            end
          end
        end
        default: ;
      endcase
    end

    // read: data registered, answered the cycle after acceptance
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = addr_mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      s_nxt.rdata  = 32'h00000000;
      unique case (S_AXI_ARADDR)
        `ADDR_INT_ENABLE:  s_nxt.rdata[7:0] = s_r.interrupt_enable;
        `ADDR_FEATURE:     s_nxt.rdata[7:0] = s_r.feature_control;
        `ADDR_ENH_FEATURE: s_nxt.rdata[7:0] = s_r.enhanced_feature;
        `ADDR_MODEM_CTRL:  s_nxt.rdata[7:0] = s_r.modem_control;
        `ADDR_INT_STATUS: begin
          isr_rd             = 1'b1;
          s_nxt.rdata[7:0]   = {s_r.fifo_en, s_r.fifo_en, code};
        end
        default: ;
      endcase
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end

    // line status: set wins over the clearing read
    s_nxt.line_pend = (s_r.line_pend & ~EVENTS.line_status_rd) |
      (s_r.interrupt_enable[`IEN_LINE] & (EVENTS.line_err != 4'h0));

    // transmit ready: two events in fifo mode, one without
    tx_below = s_r.fifo_en & (EVENTS.tx_count < {1'b0, tx_level});
    tx_empty = s_r.fifo_en
      ? ((EVENTS.tx_count == 9'h000) &
         (~s_r.feature_control[`FT_AUTO485] | EVENTS.tsr_empty))
      : EVENTS.thr_empty;
    s_nxt.tx_below_prev = tx_below;
    s_nxt.tx_empty_prev = tx_empty;
    s_nxt.ier_tx_prev   = s_r.interrupt_enable[`IEN_TX_READY];
    // an empty reached without refilling above trigger still fires once
    tx_set = s_r.interrupt_enable[`IEN_TX_READY] &
      ((tx_below & ~s_r.tx_below_prev) |
       (tx_empty & ~s_r.tx_empty_prev) |
       (tx_empty & ~s_r.ier_tx_prev));
    // status read clears it only when it is the code shown
    s_nxt.tx_pend = (s_r.tx_pend & ~EVENTS.thr_wr &
      ~(isr_rd & (code == `CODE_TX_READY))) | tx_set;

    // modem deltas
    s_nxt.modem_pend = (s_r.modem_pend & ~EVENTS.modem_status_rd) |
      (s_r.interrupt_enable[`IEN_MODEM] & (EVENTS.modem_delta != 4'h0));

    // flow or special character
    s_nxt.flow_char_pend = (s_r.flow_char_pend &
      ~(isr_rd & (code == `CODE_FLOW_CHAR))) |
      (s_r.interrupt_enable[`IEN_FLOW_CHAR] & EVENTS.flow_char_det);

    // flow pins: input pins are synchronised before the edge detector
    s_nxt.cts_meta = CTS_N_PIN;
    s_nxt.cts_sync = s_r.cts_meta;
    s_nxt.dsr_meta = DSR_N_PIN;
    s_nxt.dsr_sync = s_r.dsr_meta;
    flow_in  = s_r.modem_control[`MC_DTR_DSR] ? s_r.dsr_sync : s_r.cts_sync;
    flow_out = s_r.modem_control[`MC_DTR_DSR] ? EVENTS.dtr_out : EVENTS.rts_out;
    s_nxt.flow_in_prev  = flow_in;
    s_nxt.flow_out_prev = flow_out;
    s_nxt.flow_pin_pend = (s_r.flow_pin_pend & ~EVENTS.modem_status_rd) |
      (s_r.enhanced_feature[`EF_AUTO_CTS] & s_r.interrupt_enable[`IEN_CTS_IN] &
       flow_in & ~s_r.flow_in_prev) |
      (s_r.enhanced_feature[`EF_AUTO_RTS] & s_r.interrupt_enable[`IEN_RTS_OUT] &
       flow_out & ~s_r.flow_out_prev);

    // wake-up, reported outside the status priority
    s_nxt.wake_pend = (s_r.wake_pend & ~EVENTS.summary_rd) |
      EVENTS.wake;

    // receive time-out: bit ticks since the last push or read
    to_limit = 7'(`TO_CHARS * {3'h0, EVENTS.char_bits}) + `TO_EXTRA_BITS;
    if (EVENTS.rx_push || EVENTS.rhr_rd || !s_r.fifo_en || !rx_nonempty)
    begin
      s_nxt.timer = 7'h00;
    end else if (EVENTS.bit_tick && (s_r.timer != to_limit)) begin
      s_nxt.timer = s_r.timer + 7'h01;
    end
    // fires on the tick that reaches the limit, so it cannot refire
    to_fire = s_r.fifo_en & rx_nonempty & EVENTS.bit_tick &
              ~EVENTS.rx_push & ~EVENTS.rhr_rd &
              (s_r.timer == (to_limit - 7'h01));
    s_nxt.timeout_pend = (s_r.timeout_pend & ~EVENTS.rhr_rd) |
      (s_r.interrupt_enable[`IEN_RX_DATA] & to_fire);
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s_r      <= '0;
      s_r.interrupt_enable  <= `REG_RESET;
      s_r.feature_control <= `REG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------
  assign S_AXI_AWREADY = ~s_r.aw_held & ~s_r.bvalid;
  assign S_AXI_WREADY  = ~s_r.w_held & ~s_r.bvalid;
  assign S_AXI_BVALID  = s_r.bvalid;
  assign S_AXI_BRESP   = s_r.bresp;
  assign S_AXI_ARREADY = ~s_r.rvalid;
  assign S_AXI_RVALID  = s_r.rvalid;
  assign S_AXI_RDATA   = s_r.rdata;
  assign S_AXI_RRESP   = s_r.rresp;

  assign FIFO_ENABLE   = s_r.fifo_en;
  assign AUTO_RS485    = s_r.feature_control[`FT_AUTO485];
  assign RX_FIFO_RESET = s_r.rx_fifo_rst;
  assign TX_FIFO_RESET = s_r.tx_fifo_rst;
  assign RX_TRIGGER    = rx_level;
  assign TX_TRIGGER    = tx_level;

  assign CHANNEL_IRQ   = (code != `CODE_NONE);
  assign WAKE_IRQ      = s_r.wake_pend;

endmodule // uart_irq_top
`default_nettype wire

// ### common/uart_irq_regs.svh
// register map, field positions, codes and trigger tables of the channel
`ifndef UART_IRQ_REGS_SVH
`define UART_IRQ_REGS_SVH

// byte addresses on the register bus
`define ADDR_INT_ENABLE   8'h00
`define ADDR_INT_STATUS   8'h04
`define ADDR_FIFO_CTRL    8'h08
`define ADDR_FEATURE      8'h0C
`define ADDR_ENH_FEATURE  8'h10
`define ADDR_MODEM_CTRL   8'h14

`define REG_RESET         8'h00

// interrupt_enable fields
`define IEN_RX_DATA       0
`define IEN_TX_READY      1
`define IEN_LINE          2
`define IEN_MODEM         3
`define IEN_FLOW_CHAR     5
`define IEN_RTS_OUT       6
`define IEN_CTS_IN        7

// fifo_control fields
`define FC_ENABLE         0
`define FC_RX_RST         1
`define FC_TX_RST         2
`define FC_TX_TRG         5:4
`define FC_RX_TRG         7:6

// feature_control, enhanced_feature and modem_control fields
`define FT_AUTO485        5
`define FT_TABLE          7:6
`define EF_ENHANCED       4
`define EF_AUTO_RTS       6
`define EF_AUTO_CTS       7
`define MC_DTR_DSR        2

// interrupt_status codes, bits 5:0
`define CODE_LINE         6'h06
`define CODE_RX_DATA      6'h04
`define CODE_TIMEOUT      6'h0C
`define CODE_TX_READY     6'h02
`define CODE_MODEM        6'h00
`define CODE_FLOW_CHAR    6'h10
`define CODE_FLOW_PIN     6'h20
`define CODE_NONE         6'h01

// receive time-out span: characters and extra bit times
`define TO_CHARS          7'h04
`define TO_EXTRA_BITS     7'h0C

// trigger tables, one byte per selection, selection 0 in the low byte
`define TBL_SEL_A         2'h0
`define TBL_SEL_B         2'h1
`define TBL_SEL_C         2'h2
`define TRG_A_RX          32'h0E080401
`define TRG_A_TX          32'h01010101
`define TRG_B_RX          32'h1C181008
`define TRG_B_TX          32'h1E180810
`define TRG_C_RX          32'h3C381008
`define TRG_C_TX          32'h38201008

// bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### common/uart_irq_pkg.sv
// types shared by the channel interrupt logic
package uart_irq_pkg;

  // status and strobes from the rest of the channel, all on CLOCK
  typedef struct packed {
    logic [8:0] rx_count;
    logic [8:0] tx_count;
    logic       thr_empty;
    logic       tsr_empty;
    logic [3:0] line_err;
    logic       line_status_rd;
    logic       rhr_rd;
    logic       rx_push;
    logic       thr_wr;
    logic [3:0] modem_delta;
    logic       modem_status_rd;
    logic       flow_char_det;
    logic       rts_out;
    logic       dtr_out;
    logic       wake;
    logic       summary_rd;
    logic       bit_tick;
    logic [3:0] char_bits;
  } uart_evt_s;

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic       fifo_en;
    logic [1:0] rx_trg_sel;
    logic [1:0] tx_trg_sel;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature;
    logic [7:0] modem_control;
    logic       line_pend;
    logic       timeout_pend;
    logic       tx_pend;
    logic       modem_pend;
    logic       flow_char_pend;
    logic       flow_pin_pend;
    logic       wake_pend;
    logic       tx_below_prev;
    logic       tx_empty_prev;
    logic       ier_tx_prev;
    logic       flow_in_prev;
    logic       flow_out_prev;
    logic       cts_meta;
    logic       cts_sync;
    logic       dsr_meta;
    logic       dsr_sync;
    logic [6:0] timer;
    logic       rx_fifo_rst;
    logic       tx_fifo_rst;
    logic       aw_held;
    logic [7:0] aw_addr;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

endpackage

// ### hdl/trigger_table.sv
// trigger level lookup shared by receive and transmit
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.svh"

module trigger_table (
  // selections
  input  wire logic [1:0] TABLE_SEL,
  input  wire logic [1:0] RX_SEL,
  input  wire logic [1:0] TX_SEL,
  // programmable levels for the fourth table
  input  wire logic [7:0] PROG_RX,
  input  wire logic [7:0] PROG_TX,
  // chosen levels
  output logic      [7:0] RX_LEVEL,
  output logic      [7:0] TX_LEVEL
);

  function automatic logic [7:0] pick(input logic [31:0] word,
                                      input logic [1:0]  sel);
    pick = word[{sel, 3'h0} +: 8];
  endfunction

  // one table select feeds both directions, so they can never disagree
  always_comb begin
    unique case (TABLE_SEL)
      `TBL_SEL_A: begin
        RX_LEVEL = pick(`TRG_A_RX, RX_SEL);
        TX_LEVEL = pick(`TRG_A_TX, TX_SEL);
      end
      `TBL_SEL_B: begin
        RX_LEVEL = pick(`TRG_B_RX, RX_SEL);
        TX_LEVEL = pick(`TRG_B_TX, TX_SEL);
      end
      `TBL_SEL_C: begin
        RX_LEVEL = pick(`TRG_C_RX, RX_SEL);
        TX_LEVEL = pick(`TRG_C_TX, TX_SEL);
      end
      default: begin
        RX_LEVEL = PROG_RX;
        TX_LEVEL = PROG_TX;
      end
    endcase
  end

endmodule // trigger_table
`default_nettype wire

// ### test/uart_irq_chk.sv
// assertions on bus answers and status reads of the channel interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.svh"

module uart_irq_chk (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST_N,
  // register bus
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_BVALID,
  // channel side
  input wire logic        FIFO_ENABLE,
  input wire logic        RX_FIFO_RESET,
  input wire logic        CHANNEL_IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // answer to a status read lands now; address was taken one edge ago
  sequence st_rd;
    $rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == `ADDR_INT_STATUS;
  endsequence

  irq_bit0_a: assert property (
    st_rd |-> S_AXI_RDATA[0] == !$past(CHANNEL_IRQ))
    else $error("status bit 0 disagrees with the request line");
  fifo_bits_a: assert property (
    st_rd |-> S_AXI_RDATA[7:6] == {2{$past(FIFO_ENABLE)}})
    else $error("status bits 7:6 do not follow fifo enable");
  status_code_a: assert property (
    st_rd |-> S_AXI_RDATA[5:0] inside {6'h06, 6'h04, 6'h0C, 6'h02,
                                       6'h00, 6'h10, 6'h20, 6'h01})
    else $error("status code outside the priority table");
  read_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer not one cycle after address");
  read_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address accepted while answer stands");
  rdata_upper_a: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  fifo_write_a: assert property (
    $changed(FIFO_ENABLE) |-> $rose(S_AXI_BVALID))
    else $error("fifo enable changed without a write");
  fifo_reset_a: assert property (
    RX_FIFO_RESET |-> FIFO_ENABLE ##1 !RX_FIFO_RESET)
    else $error("receive fifo reset not a single gated pulse");

  cover property (st_rd ##0 !S_AXI_RDATA[0]);
  cover property (st_rd ##0 S_AXI_RDATA[7]);
  cover property (RX_FIFO_RESET);
endmodule // uart_irq_chk

bind uart_irq_top uart_irq_chk u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_BVALID(S_AXI_BVALID), .FIFO_ENABLE(FIFO_ENABLE),
  .RX_FIFO_RESET(RX_FIFO_RESET), .CHANNEL_IRQ(CHANNEL_IRQ)
);

`default_nettype wire

// ### test/test_uart_irq_top.sv
// self-checking bench of the channel interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.svh"

module test_uart_irq_top;
  import uart_irq_pkg::*;
  localparam logic [7:0] IE = `ADDR_INT_ENABLE;
  localparam logic [7:0] ST = `ADDR_INT_STATUS;
  localparam logic [7:0] FC = `ADDR_FIFO_CTRL;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx_trg, tx_trg;
  logic [31:0] wdata = 32'h0, rdata, d_x;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1, awready, wready, arready;
  logic        bvalid, rvalid, fifo_enable, rx_rst, channel_irq, wake_irq;
  logic        auto485, cts_n = 1'b1;
  logic [1:0]  bresp, rresp, r_x;
  uart_evt_s   ev = '0;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0;

  uart_irq_top DUT (
    .CLOCK(clock), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EVENTS(ev),
    .PROG_RX_TRIGGER(8'h2A), .PROG_TX_TRIGGER(8'h15), .CTS_N_PIN(cts_n),
    .DSR_N_PIN(1'b1), .FIFO_ENABLE(fifo_enable), .AUTO_RS485(auto485),
    .RX_FIFO_RESET(rx_rst), .TX_FIFO_RESET(), .RX_TRIGGER(rx_trg),
    .TX_TRIGGER(tx_trg), .CHANNEL_IRQ(channel_irq), .WAKE_IRQ(wake_irq)
  );

  always #12.5 clock = ~clock;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready lines can fall, so each valid drops on the edge that sees its own ready
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        check({30'h0, bresp}, 32'h0);
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    step(3);
    rchk(ST, 32'h01);
    rchk(IE, 32'h00);
    rd(8'h40, d_x, r_x);
    check({30'h0, r_x}, 32'h2);
    $display("test reset values done");
    ev.thr_empty <= 1'b1;
    wr(IE, 8'h02);
    rchk(ST, 32'h02);
    rchk(ST, 32'h01);
    ev.thr_empty <= 1'b0;
    step(1);
    ev.thr_empty <= 1'b1;
    step(2);
    check({31'h0, channel_irq}, 32'h1);
    ev.thr_wr <= 1'b1;
    step(1);
    ev.thr_wr <= 1'b0;
    step(1);
    rchk(ST, 32'h01);
    $display("test transmit ready done");
    wr(IE, 8'h07);
    ev.rx_count <= 9'h001;
    ev.line_err <= 4'h2;
    step(2);
    rchk(ST, 32'h06);
    ev.line_err <= 4'h0;
    ev.line_status_rd <= 1'b1;
    step(1);
    ev.line_status_rd <= 1'b0;
    step(1);
    rchk(ST, 32'h04);
    ev.rx_count <= 9'h000;
    rchk(ST, 32'h01);
    $display("test line and receive done");
    wr(IE, 8'h28);
    ev.modem_delta <= 4'h1;
    ev.flow_char_det <= 1'b1;
    step(1);
    ev.flow_char_det <= 1'b0;
    step(1);
    rchk(ST, 32'h00);
    rchk(ST, 32'h00);
    ev.modem_delta <= 4'h0;
    ev.modem_status_rd <= 1'b1;
    step(1);
    ev.modem_status_rd <= 1'b0;
    step(1);
    rchk(ST, 32'h10);
    rchk(ST, 32'h01);
    ev.wake <= 1'b1;
    step(1);
    ev.wake <= 1'b0;
    step(1);
    check({31'h0, wake_irq}, 32'h1);
    ev.summary_rd <= 1'b1;
    step(1);
    ev.summary_rd <= 1'b0;
    step(1);
    check({31'h0, wake_irq}, 32'h0);
    $display("test modem, character and wake done");
    wr(FC, 8'hC3);
    rchk(ST, 32'hC1);
    check({24'h0, rx_trg}, 32'h0E);
    wr(FC, 8'h40);
    check({31'h0, fifo_enable}, 32'h0);
    check({24'h0, rx_trg}, 32'h0E);
    wr(`ADDR_FEATURE, 8'h40);
    wr(FC, 8'h21);
    check({24'h0, tx_trg}, 32'h10);
    check({24'h0, rx_trg}, 32'h08);
    wr(`ADDR_ENH_FEATURE, 8'h10);
    wr(FC, 8'hB1);
    check({24'h0, tx_trg}, 32'h1E);
    check({24'h0, rx_trg}, 32'h18);
    $display("test fifo control done");
    ev.tx_count <= 9'h028;
    wr(IE, 8'h02);
    rchk(ST, 32'hC1);
    ev.tx_count <= 9'h01D;
    step(2);
    rchk(ST, 32'hC2);
    wr(`ADDR_FEATURE, 8'h60);
    check({31'h0, auto485}, 32'h1);
    ev.tx_count <= 9'h000;
    step(2);
    rchk(ST, 32'hC1);
    ev.tsr_empty <= 1'b1;
    step(2);
    rchk(ST, 32'hC2);
    $display("test transmit fifo done");
    wr(IE, 8'h01);
    ev.rx_count <= 9'h018;
    rchk(ST, 32'hC4);
    ev.rx_count <= 9'h017;
    rchk(ST, 32'hC1);
    // four 10-bit characters plus 12 bits: fires on the 52nd tick
    ev.char_bits <= 4'hA;
    ev.bit_tick <= 1'b1;
    step(51);
    ev.bit_tick <= 1'b0;
    step(1);
    check({31'h0, channel_irq}, 32'h0);
    ev.bit_tick <= 1'b1;
    step(1);
    ev.bit_tick <= 1'b0;
    rchk(ST, 32'hCC);
    ev.rhr_rd <= 1'b1;
    step(1);
    ev.rhr_rd <= 1'b0;
    rchk(ST, 32'hC1);
    $display("test receive time-out done");
    wr(`ADDR_ENH_FEATURE, 8'h90);
    wr(IE, 8'h80);
    cts_n <= 1'b0;
    step(4);
    cts_n <= 1'b1;
    step(4);
    rchk(ST, 32'hE0);
    ev.modem_status_rd <= 1'b1;
    step(1);
    ev.modem_status_rd <= 1'b0;
    rchk(ST, 32'hC1);
    wr(`ADDR_FEATURE, 8'hC0);
    check({16'h0, rx_trg, tx_trg}, 32'h2A15);
    $display("test flow pin and programmable table done");
    stop_test();
  end
endmodule // test_uart_irq_top

`default_nettype wire
